/* logic_eval_defs.svh */
`ifndef LOGIC_EVAL_DEFS_SVH
`define LOGIC_EVAL_DEFS_SVH

// Timing
`define CLK_PERIOD_NS 10
`define TICK_PERIOD_MS 10
`define NS_PER_MS 1000000
`define TIMER_COUNTS_PER_SEC 100

// Statement program
`define STMT_COUNT 30
`define STMT_IDX_W 5
`define STMT_WORD_W 32
`define F_COND1_HI 31
`define F_COND1_LO 24
`define F_OPER_HI 23
`define F_OPER_LO 16
`define F_COND2_HI 15
`define F_COND2_LO 8
`define F_ACT_HI 7
`define F_ACT_LO 0
`define F_DISABLE_BIT 23

// Operator codes
`define OP_OR 8'h00
`define OP_AND 8'h01
`define OP_XOR 8'h02
`define OP_NAND 8'h03
`define OP_NOR 8'h04
`define OP_XNOR 8'h05

// Condition codes
`define COND_FALSE 8'h00
`define COND_TRUE 8'h01
`define COND_CORE_FIRST 8'h02
`define COND_CORE_LAST 8'h4B
`define COND_CMP_A_WIN 8'h4C
`define COND_CMP_B_WIN 8'h4D
`define COND_A_LT_B 8'h58
`define COND_A_EQ_B 8'h59
`define COND_A_GT_B 8'h5A
`define COND_TMR_RUN_BASE 8'h64
`define COND_TMR_DONE_BASE 8'h68
`define CORE_COND_W 76

// Action codes
`define ACT_NONE 8'h00
`define ACT_CORE_LAST 8'h63
`define ACT_TMR_START_BASE 8'h64
`define ACT_TMR_STOP_BASE 8'h68

// Comparator scaling
`define PCT_SCALE 40'h00_0000_0064

// Timers
`define TIMER_NUM 4
`define TIMER_W 16
`define TIMER_STOPPED 16'hFFFF
`define TIMER_ZERO 16'h0000

// Register byte addresses
`define ADDR_W 12
`define A_STMT_BASE 12'h000
`define A_STMT_END 12'h074
`define A_CMP_A_PTR 12'h080
`define A_CMP_A_WIN 12'h084
`define A_CMP_B_PTR 12'h088
`define A_CMP_B_WIN 12'h08C
`define A_CMP_A_CTR 12'h090
`define A_CMP_B_CTR 12'h094
`define A_TMR_PRESET_BASE 12'h0A0
`define A_TMR_MON_BASE 12'h0B0
`define A_CONTROL 12'h0C0
`define A_STATUS 12'h0C4

// Control and status bits
`define CTRL_MODE_BIT 0
`define ST_LOADED_BIT 0
`define ST_RUN_BIT 1
`define ST_BUSY_BIT 2

`endif

/* logic_eval_pkg.sv */
package logic_eval_pkg;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SAMPLE = 2'b01,
      ST_EVAL = 2'b10
   } eval_state_e;

   typedef logic [15:0] half_t;
endpackage

/* logic_statement_evaluator.sv */
`timescale 1ns/1ps
`include "logic_eval_defs.svh"

module logic_statement_evaluator
   import logic_eval_pkg::*;
#(
   parameter int TICK_CYCLES = `TICK_PERIOD_MS * (`NS_PER_MS / `CLK_PERIOD_NS)
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Drive core status
   input wire logic drive_enabled,
   input wire logic remote_mode,
   input wire logic [`CORE_COND_W-1:0] core_cond,
   // Pointed parameter values for the comparators
   input wire logic signed [15:0] src_a_value,
   input wire logic [15:0] src_a_max,
   input wire logic signed [15:0] src_b_value,
   input wire logic [15:0] src_b_max,
   // Comparator source pointers toward the core
   output logic [15:0] comparator_a_source_pointer,
   output logic [15:0] comparator_b_source_pointer,
   // Actions toward the core
   output logic action_valid,
   output logic [7:0] action_id,
   output logic action_alt,
   // Engine state
   output logic engine_running
);

   localparam int TICK_W = $clog2(TICK_CYCLES + 1);

   logic [`STMT_WORD_W-1:0] table_r [`STMT_COUNT];
   logic [`STMT_WORD_W-1:0] prog_r [`STMT_COUNT];
   half_t a_ptr_r, b_ptr_r;
   logic signed [15:0] a_win_r, b_win_r, a_ctr_r, b_ctr_r;
   half_t preset_r [`TIMER_NUM];
   half_t cnt_r [`TIMER_NUM];
   logic mode_r, loaded_r, remote_q_r;
   logic [31:0] prdata_r;
   logic pready_r, pslverr_r;
   logic action_valid_r, action_alt_r;
   logic [7:0] action_id_r;
   eval_state_e state_r;
   logic [`STMT_IDX_W-1:0] idx_r;
   logic [TICK_W-1:0] tick_cnt_r;
   logic tick_r, running_r;
   logic cmp_a_win_r, cmp_b_win_r, cmp_lt_r, cmp_eq_r, cmp_gt_r;

   logic access, wr_en, mapped;
   logic [31:0] rd_val;
   logic [`TIMER_NUM-1:0] tmr_run, tmr_done, tmr_start, tmr_stop;

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign comparator_a_source_pointer = a_ptr_r;
   assign comparator_b_source_pointer = b_ptr_r;
   assign action_valid = action_valid_r;
   assign action_id = action_id_r;
   assign action_alt = action_alt_r;
   assign engine_running = running_r;

   // One wait state: data is prepared first, effect lands with pready
   assign access = psel && penable && !pready_r;
   assign wr_en = psel && penable && pready_r && pwrite;

   // Condition lookup; upper bit flags a defined code
   function automatic logic [1:0] cond_eval(input logic [7:0] id);
      logic [1:0] r;
      r = 2'b00;
      if (id == `COND_FALSE)
         r = 2'b10;
      else if (id == `COND_TRUE)
         r = 2'b11;
      else if (id >= `COND_CORE_FIRST && id <= `COND_CORE_LAST)
         r = {1'b1, core_cond[id[6:0]]};
      else if (id == `COND_CMP_A_WIN)
         r = {1'b1, cmp_a_win_r};
      else if (id == `COND_CMP_B_WIN)
         r = {1'b1, cmp_b_win_r};
      else if (id == `COND_A_LT_B)
         r = {1'b1, cmp_lt_r};
      else if (id == `COND_A_EQ_B)
         r = {1'b1, cmp_eq_r};
      else if (id == `COND_A_GT_B)
         r = {1'b1, cmp_gt_r};
      else if (id >= `COND_TMR_RUN_BASE && id < `COND_TMR_DONE_BASE)
         r = {1'b1, tmr_run[id[1:0]]};
      else if (id >= `COND_TMR_DONE_BASE && id < `COND_TMR_DONE_BASE + 8'(`TIMER_NUM))
         r = {1'b1, tmr_done[id[1:0]]};
      return r;
   endfunction

   // Current statement decode
   logic [`STMT_WORD_W-1:0] word;
   logic [7:0] c1_id, op_id, c2_id, act_id;
   logic [1:0] c1, c2;
   logic op_ok, res, act_ok, is_core_act, is_start, is_stop, fire;
   always_comb begin
      word = prog_r[idx_r];
      c1_id = word[`F_COND1_HI:`F_COND1_LO];
      op_id = word[`F_OPER_HI:`F_OPER_LO];
      c2_id = word[`F_COND2_HI:`F_COND2_LO];
      act_id = word[`F_ACT_HI:`F_ACT_LO];
      c1 = cond_eval(c1_id);
      c2 = cond_eval(c2_id);
      op_ok = 1'b1;
      unique case (op_id)
         `OP_OR: res = c1[0] | c2[0];
         `OP_AND: res = c1[0] & c2[0];
         `OP_XOR: res = c1[0] ^ c2[0];
         `OP_NAND: res = ~(c1[0] & c2[0]);
         `OP_NOR: res = ~(c1[0] | c2[0]);
         `OP_XNOR: res = ~(c1[0] ^ c2[0]);
         default: begin
            res = 1'b0;
            op_ok = 1'b0;
         end
      endcase
      is_core_act = act_id != `ACT_NONE && act_id <= `ACT_CORE_LAST;
      is_start = act_id >= `ACT_TMR_START_BASE && act_id < `ACT_TMR_STOP_BASE;
      is_stop = act_id >= `ACT_TMR_STOP_BASE && act_id < `ACT_TMR_STOP_BASE + 8'(`TIMER_NUM);
      act_ok = is_core_act || is_start || is_stop;
      // disabled or undefined statements are skipped
      fire = state_r == ST_EVAL && !word[`F_DISABLE_BIT] && op_ok && c1[1] && c2[1] && act_ok;
   end

   // Tick generator
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tick_cnt_r <= '0;
         tick_r <= 1'b0;
      end else if (tick_cnt_r == TICK_W'(TICK_CYCLES - 1)) begin
         tick_cnt_r <= '0;
         tick_r <= 1'b1;
      end else begin
         tick_cnt_r <= tick_cnt_r + 1'b1;
         tick_r <= 1'b0;
      end
   end

   // Sequencer
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
         idx_r <= '0;
         running_r <= 1'b0;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               // only in logic mode, once per tick
               if (tick_r && mode_r && loaded_r) begin
                  state_r <= ST_SAMPLE;
                  running_r <= 1'b1;
               end
            end
            ST_SAMPLE: begin
               idx_r <= '0;
               state_r <= ST_EVAL;
            end
            ST_EVAL: begin
               if (idx_r == `STMT_IDX_W'(`STMT_COUNT - 1)) begin
                  state_r <= ST_IDLE;
                  running_r <= 1'b0;
               end else
                  idx_r <= idx_r + 1'b1;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // Comparators; products avoid any division
   logic signed [39:0] va, vb, ma, mb, da, db, wa, wb;
   always_comb begin
      va = 40'(src_a_value);
      vb = 40'(src_b_value);
      ma = 40'({1'b0, src_a_max});
      mb = 40'({1'b0, src_b_max});
      // scaled form of abs(A - ctr/100) <= win/100
      da = `PCT_SCALE * va - 40'(a_ctr_r) * ma;
      db = `PCT_SCALE * vb - 40'(b_ctr_r) * mb;
      wa = 40'(a_win_r) * ma;
      wb = 40'(b_win_r) * mb;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cmp_a_win_r <= 1'b0;
         cmp_b_win_r <= 1'b0;
         cmp_lt_r <= 1'b0;
         cmp_eq_r <= 1'b0;
         cmp_gt_r <= 1'b0;
      end else if (state_r == ST_SAMPLE) begin
         cmp_a_win_r <= (da < 0 ? -da : da) <= wa;
         cmp_b_win_r <= (db < 0 ? -db : db) <= wb;
         cmp_lt_r <= va * mb < vb * ma;
         cmp_eq_r <= va * mb == vb * ma;
         cmp_gt_r <= va * mb > vb * ma;
      end
   end

   // Actions to the core, one per fired statement with a core action code
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         action_valid_r <= 1'b0;
         action_id_r <= '0;
         action_alt_r <= 1'b0;
      end else begin
         // true is primary, false is alternate
         action_valid_r <= fire && is_core_act;
         if (fire && is_core_act) begin
            action_id_r <= act_id;
            action_alt_r <= !res;
         end
      end
   end

   // program copied only on entering remote mode
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         remote_q_r <= 1'b0;
         loaded_r <= 1'b0;
         for (int i = 0; i < `STMT_COUNT; i++)
            prog_r[i] <= '0;
      end else begin
         remote_q_r <= remote_mode;
         // reload relies on enable preceding remote
         if (remote_mode && !remote_q_r && drive_enabled) begin
            loaded_r <= 1'b1;
            for (int i = 0; i < `STMT_COUNT; i++)
               prog_r[i] <= table_r[i];
         end
      end
   end

   // Timers
   for (genvar t = 0; t < `TIMER_NUM; t++) begin : g_tmr
      logic mon_wr;
      assign mon_wr = wr_en && paddr == `A_TMR_MON_BASE + `ADDR_W'(4 * t);
      assign tmr_run[t] = cnt_r[t] != `TIMER_STOPPED && cnt_r[t] < preset_r[t];
      assign tmr_done[t] = cnt_r[t] != `TIMER_STOPPED && cnt_r[t] >= preset_r[t];
      // timer actions fire regardless of outcome polarity
      assign tmr_start[t] = fire && is_start && act_id[1:0] == 2'(t);
      assign tmr_stop[t] = fire && is_stop && act_id[1:0] == 2'(t);

      always_ff @(posedge clk) begin
         if (!rst_n) begin
            preset_r[t] <= '0;
            cnt_r[t] <= `TIMER_STOPPED;
         end else begin
            if (wr_en && paddr == `A_TMR_PRESET_BASE + `ADDR_W'(4 * t))
               preset_r[t] <= pwdata[15:0];
            // software write wins; zero starts, max stops
            if (mon_wr)
               cnt_r[t] <= pwdata[15:0];
            else if (tmr_start[t])
               cnt_r[t] <= `TIMER_ZERO;
            else if (tmr_stop[t])
               cnt_r[t] <= `TIMER_STOPPED;
            // one count per 10 ms tick
            else if (tick_r && tmr_run[t])
               cnt_r[t] <= cnt_r[t] + 1'b1;
         end
      end
   end

   // Register writes
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         for (int i = 0; i < `STMT_COUNT; i++)
            table_r[i] <= '0;
         a_ptr_r <= '0;
         b_ptr_r <= '0;
         a_win_r <= '0;
         b_win_r <= '0;
         a_ctr_r <= '0;
         b_ctr_r <= '0;
         mode_r <= 1'b0;
      end else if (wr_en) begin
         if (paddr <= `A_STMT_END && paddr[1:0] == 2'b00)
            table_r[paddr[6:2]] <= pwdata;
         unique case (paddr)
            `A_CMP_A_PTR: a_ptr_r <= pwdata[15:0];
            `A_CMP_B_PTR: b_ptr_r <= pwdata[15:0];
            `A_CMP_A_WIN: a_win_r <= pwdata[15:0];
            `A_CMP_B_WIN: b_win_r <= pwdata[15:0];
            `A_CMP_A_CTR: a_ctr_r <= pwdata[15:0];
            `A_CMP_B_CTR: b_ctr_r <= pwdata[15:0];
            `A_CONTROL: mode_r <= pwdata[`CTRL_MODE_BIT];
            default: ;
         endcase
      end
   end

   // Read decode
   always_comb begin
      rd_val = '0;
      mapped = 1'b1;
      if (paddr <= `A_STMT_END && paddr[1:0] == 2'b00)
         rd_val = table_r[paddr[6:2]];
      else if (paddr >= `A_TMR_PRESET_BASE && paddr < `A_TMR_MON_BASE && paddr[1:0] == 2'b00)
         rd_val = {16'h0000, preset_r[paddr[3:2]]};
      else if (paddr >= `A_TMR_MON_BASE && paddr < `A_CONTROL && paddr[1:0] == 2'b00)
         rd_val = {16'h0000, cnt_r[paddr[3:2]]};
      else begin
         unique case (paddr)
            `A_CMP_A_PTR: rd_val = {16'h0000, a_ptr_r};
            `A_CMP_B_PTR: rd_val = {16'h0000, b_ptr_r};
            `A_CMP_A_WIN: rd_val = {16'h0000, a_win_r};
            `A_CMP_B_WIN: rd_val = {16'h0000, b_win_r};
            `A_CMP_A_CTR: rd_val = {16'h0000, a_ctr_r};
            `A_CMP_B_CTR: rd_val = {16'h0000, b_ctr_r};
            `A_CONTROL: rd_val[`CTRL_MODE_BIT] = mode_r;
            `A_STATUS: begin
               rd_val[`ST_LOADED_BIT] = loaded_r;
               rd_val[`ST_RUN_BIT] = mode_r && loaded_r;
               rd_val[`ST_BUSY_BIT] = state_r != ST_IDLE;
            end
            default: mapped = 1'b0;
         endcase
      end
   end

   // APB answer
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= '0;
      end else begin
         pready_r <= access;
         pslverr_r <= access && !mapped;
         if (access && !pwrite)
            prdata_r <= rd_val;
      end
   end

endmodule

/* logic_eval_monitor.sv */
`timescale 1ns/1ps
`include "logic_eval_defs.svh"
module logic_eval_monitor
   import logic_eval_pkg::*;
#(
   parameter int TICK_CYCLES = 50
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Engine outputs
   input wire logic [15:0] comparator_a_source_pointer,
   input wire logic action_valid,
   input wire logic [7:0] action_id,
   input wire logic action_alt,
   input wire logic engine_running
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic run_r;
   logic seen_r;
   int cnt_r;
   // Cycles since the last start of evaluation
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         run_r <= 1'b0;
         seen_r <= 1'b0;
         cnt_r <= 0;
      end else begin
         run_r <= engine_running;
         if (engine_running && !run_r) begin
            cnt_r <= 1;
            seen_r <= 1'b1;
         end else if (cnt_r < 1000000) begin
            cnt_r <= cnt_r + 1;
         end
      end
   end
   a_run_length:
      assert property (!engine_running && run_r |-> cnt_r == 31) else $error("evaluation span wrong");
   a_tick_period:
      assert property (engine_running && !run_r && seen_r |-> cnt_r % TICK_CYCLES == 0) else $error("tick spacing wrong");
   a_action_window:
      assert property (action_valid |-> seen_r && cnt_r >= 2 && cnt_r <= 31) else $error("action outside tick");
   a_action_code:
      assert property (action_valid |-> action_id != `ACT_NONE && action_id <= `ACT_CORE_LAST)
         else $error("bad action code");
   a_action_hold:
      assert property (!action_valid |-> $stable(action_id) && $stable(action_alt)) else $error("action changed");
   a_bus_wait:
      assert property (psel && penable && !$past(penable) |-> !pready ##1 pready) else $error("wait state wrong");
   a_ready_pulse:
      assert property (pready |=> !pready) else $error("ready not a pulse");
   a_err_read:
      assert property (pslverr |-> pready && (pwrite || prdata == 32'h0000_0000)) else $error("error reply wrong");
   a_ptr_write:
      assert property (psel && penable && pready && pwrite && paddr == `A_CMP_A_PTR |=>
         {16'h0000, comparator_a_source_pointer} == ($past(pwdata) & 32'h0000_FFFF)) else $error("pointer stale");
endmodule

bind logic_statement_evaluator logic_eval_monitor #(.TICK_CYCLES(TICK_CYCLES)) mon (
   .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .comparator_a_source_pointer(comparator_a_source_pointer), .action_valid(action_valid),
   .action_id(action_id), .action_alt(action_alt), .engine_running(engine_running)
);

/* drive_core_model.sv */
`timescale 1ns/1ps
module drive_core_model (
   // Clock
   input wire logic clk,
   // Actions from the engine
   input wire logic action_valid,
   input wire logic [7:0] action_id,
   input wire logic action_alt,
   // Core status
   output logic drive_enabled,
   output logic remote_mode,
   output logic [75:0] core_cond,
   // Pointed parameter values
   output logic signed [15:0] src_a_value,
   output logic [15:0] src_a_max,
   output logic signed [15:0] src_b_value,
   output logic [15:0] src_b_max
);
   logic [7:0] hits [256];
   logic alt_seen [256];
   int total;
   task clr;
      for (int i = 0; i < 256; i++) begin
         hits[i] <= 8'h00;
         alt_seen[i] <= 1'b0;
      end
      total <= 0;
   endtask
   task load;
      drive_enabled <= 1'b0;
      remote_mode <= 1'b0;
      repeat (2) @(posedge clk);
      drive_enabled <= 1'b1;
      @(posedge clk);
      remote_mode <= 1'b1;
      @(posedge clk);
   endtask
   initial begin
      drive_enabled = 1'b0;
      remote_mode = 1'b0;
      core_cond = 76'h000_0000_0000_0000_0020;
      src_a_value = 16'h0001;
      src_a_max = 16'h0002;
      src_b_value = 16'h0001;
      src_b_max = 16'h0004;
      clr();
   end
   always @(posedge clk) begin
      if (action_valid === 1'b1) begin
         hits[action_id] <= hits[action_id] + 8'h01;
         alt_seen[action_id] <= action_alt;
         total <= total + 1;
      end
   end
endmodule

/* tb_logic_statement_evaluator.sv */
`timescale 1ns/1ps
`include "logic_eval_defs.svh"
module tb_logic_statement_evaluator
   import logic_eval_pkg::*;
;
   localparam int TICK = 50;
   localparam logic [7:0] C1 [16] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01,
      8'h58, 8'h59, 8'h5A, 8'h4C, 8'h4D, 8'h05, 8'h64, 8'h68};
   localparam logic [7:0] OPS [16] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h80, 8'h07,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   localparam logic [15:0] ALT = 16'hD332;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, rerr;
   logic [`ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic drive_enabled, remote_mode, action_valid, action_alt, engine_running;
   logic [75:0] core_cond;
   logic signed [15:0] src_a_value, src_b_value;
   logic [15:0] src_a_max, src_b_max, ptr_a, ptr_b;
   logic [7:0] action_id;
   int num_errors, checked;
   logic_statement_evaluator #(.TICK_CYCLES(TICK)) uut (.clk(clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .drive_enabled(drive_enabled), .remote_mode(remote_mode),
      .core_cond(core_cond), .src_a_value(src_a_value), .src_a_max(src_a_max),
      .src_b_value(src_b_value), .src_b_max(src_b_max), .comparator_a_source_pointer(ptr_a),
      .comparator_b_source_pointer(ptr_b), .action_valid(action_valid), .action_id(action_id),
      .action_alt(action_alt), .engine_running(engine_running));
   drive_core_model core (.clk(clk), .action_valid(action_valid), .action_id(action_id),
      .action_alt(action_alt), .drive_enabled(drive_enabled), .remote_mode(remote_mode),
      .core_cond(core_cond), .src_a_value(src_a_value), .src_a_max(src_a_max),
      .src_b_value(src_b_value), .src_b_max(src_b_max));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task end_sim;
      if (num_errors == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task apb(input logic wr, input logic [`ADDR_W-1:0] a, input logic [31:0] d);
      int i;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (pready !== 1'b1 && i < 50);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i >= 50) num_errors++;
      @(posedge clk);
   endtask
   // Waits for one whole evaluation pass plus its trailing pulse
   task tick;
      int i;
      i = 0;
      while (engine_running !== 1'b1 && i < 300) begin
         @(posedge clk);
         i++;
      end
      while (engine_running === 1'b1 && i < 300) begin
         @(posedge clk);
         i++;
      end
      repeat (3) @(posedge clk);
      if (i >= 300) num_errors++;
   endtask
   function logic [31:0] w(input logic [7:0] c1, input logic [7:0] op, input logic [7:0] c2, input logic [7:0] a);
      return {c1, op, c2, a};
   endfunction
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      num_errors = 0;
      checked = 0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      apb(1'b0, `A_TMR_MON_BASE, 32'h0000_0000);
      chk(rdata, 32'h0000_FFFF);
      apb(1'b0, `A_STMT_BASE, 32'h0000_0000);
      chk(rdata, 32'h0000_0000);
      apb(1'b0, 12'h0F0, 32'h0000_0000);
      chk(rerr, 32'h0000_0001);
      apb(1'b1, `A_CMP_A_PTR, 32'h0000_0005);
      apb(1'b1, `A_CMP_B_PTR, 32'h0000_0006);
      apb(1'b1, `A_CMP_A_CTR, 32'h0000_0032);
      apb(1'b1, `A_CMP_A_WIN, 32'h0000_0000);
      apb(1'b1, `A_CMP_B_CTR, 32'h0000_0000);
      apb(1'b1, `A_CMP_B_WIN, 32'h0000_0014);
      apb(1'b1, `A_TMR_PRESET_BASE, 32'h0000_0002);
      apb(1'b1, `A_TMR_PRESET_BASE + 12'h004, 32'h0000_0003);
      chk(ptr_a, 32'h0000_0005);
      chk(ptr_b, 32'h0000_0006);
      for (int k = 0; k < 16; k++) apb(1'b1, `A_STMT_BASE + 12'(4 * k), w(C1[k], OPS[k], 8'h00, 8'h0A + 8'(k)));
      apb(1'b1, `A_CONTROL, 32'h0000_0001);
      core.load();
      tick();
      core.clr();
      tick();
      for (int k = 0; k < 16; k++) begin
         if (k != 6 && k != 7) begin
            chk(core.hits[10 + k], 32'h0000_0001);
            chk(core.alt_seen[10 + k], ALT[k]);
         end
      end
      chk(core.total, 32'h0000_000E);
      apb(1'b1, `A_STMT_BASE + 12'h040, w(8'h01, 8'h00, 8'h00, 8'h66));
      apb(1'b1, `A_STMT_BASE + 12'h044, w(8'h00, 8'h00, 8'h00, 8'h69));
      apb(1'b1, `A_TMR_MON_BASE, 32'h0000_0000);
      apb(1'b1, `A_TMR_MON_BASE + 12'h004, 32'h0000_0000);
      repeat (5) tick();
      apb(1'b0, `A_TMR_MON_BASE, 32'h0000_0000);
      chk(rdata, 32'h0000_0002);
      apb(1'b0, `A_TMR_MON_BASE + 12'h004, 32'h0000_0000);
      chk(rdata, 32'h0000_0003);
      core.clr();
      tick();
      chk(core.alt_seen[24], 32'h0000_0001);
      chk(core.alt_seen[25], 32'h0000_0000);
      apb(1'b1, `A_TMR_MON_BASE, 32'h0000_FFFF);
      apb(1'b0, `A_TMR_MON_BASE, 32'h0000_0000);
      chk(rdata, 32'h0000_FFFF);
      core.clr();
      tick();
      chk(core.alt_seen[25], 32'h0000_0001);
      apb(1'b1, `A_STMT_BASE, w(8'h01, 8'h00, 8'h00, 8'h3C));
      core.clr();
      tick();
      chk(core.hits[60], 32'h0000_0000);
      chk(core.hits[10], 32'h0000_0001);
      core.load();
      core.clr();
      tick();
      chk(core.hits[60], 32'h0000_0001);
      chk(core.hits[10], 32'h0000_0000);
      apb(1'b1, `A_CONTROL, 32'h0000_0000);
      core.clr();
      repeat (2 * TICK) @(posedge clk);
      chk(core.total, 32'h0000_0000);
      chk(engine_running, 32'h0000_0000);
      apb(1'b0, `A_TMR_MON_BASE + 12'h008, 32'h0000_0000);
      chk(rdata, 32'h0000_0000);
      apb(1'b0, `A_TMR_MON_BASE + 12'h004, 32'h0000_0000);
      chk(rdata, 32'h0000_FFFF);
      end_sim();
   end
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      end_sim();
   end
endmodule
